// ==== test/module_pin_model.sv ====
// Far-side model: module pins and the converter's first-pass signal
`timescale 1ns/1ns
module module_pin_model #(
  parameter int CONV_CYCLES = 40
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [4:0] pin_req,
  output logic            transmit_off_pin,
  output logic            transmit_fault_pin,
  output logic            receive_signal_lost_pin,
  output logic            rate_sel_a_pin,
  output logic            rate_sel_b_pin,
  output logic            adc_all_converted
);
  // ==========================================================
  // Pin levels change off the sampling edge, like slow board logic
  int unsigned conv_cnt;
  initial begin
    {transmit_off_pin, transmit_fault_pin, receive_signal_lost_pin} = 3'h0;
    {rate_sel_a_pin, rate_sel_b_pin} = 2'h0;
    adc_all_converted = 1'b0;
    conv_cnt = 0;
  end
  always @(negedge mclk) begin
    {transmit_off_pin, transmit_fault_pin, receive_signal_lost_pin} <= pin_req[4:2];
    {rate_sel_a_pin, rate_sel_b_pin} <= pin_req[1:0];
    // Level held after the first full pass, a pulse would also do
    conv_cnt <= rst_n ? conv_cnt + 1 : 0;
    adc_all_converted <= rst_n && (conv_cnt >= CONV_CYCLES);
  end
endmodule // module_pin_model

// ==== test/tb_transceiver_control_rate_select.sv ====
// Self-checking bench for the control/status and rate-select block
`timescale 1ns/1ns
module tb_transceiver_control_rate_select;
  logic       mclk, rst_n, reg_wr_en, reg_rd_en, table_wr_en, tx_soft_rate_bit;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic [5:0] table_wr_idx;
  logic [1:0] table_wr_data;
  logic [4:0] pin_req;
  logic       tx_off, fault, lost, rsa, rsb, adc_done, laser_off, rx_rate, tx_rate, rd_d;
  logic [10:0] exp_q[$];
  logic [10:0] e;
  logic [10:0] exp_note;
  logic [1:0]  tbl [64];
  logic [31:0] r;
  logic [7:0]  st, m;
  int n_errors, check_count;
  // ==========================================================
  // Clock, partner and design
  always #50 mclk = ~mclk;
  module_pin_model #(.CONV_CYCLES(40)) far (.mclk(mclk), .rst_n(rst_n), .pin_req(pin_req),
    .transmit_off_pin(tx_off), .transmit_fault_pin(fault), .receive_signal_lost_pin(lost),
    .rate_sel_a_pin(rsa), .rate_sel_b_pin(rsb), .adc_all_converted(adc_done));
  transceiver_control_rate_select #(.TABLE_DEPTH(64)) dut (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .table_wr_en(table_wr_en),
    .table_wr_idx(table_wr_idx), .table_wr_data(table_wr_data), .transmit_off_pin(tx_off),
    .transmit_fault_pin(fault), .receive_signal_lost_pin(lost), .rate_sel_a_pin(rsa),
    .rate_sel_b_pin(rsb), .tx_soft_rate_bit(tx_soft_rate_bit), .adc_all_converted(adc_done),
    .laser_off(laser_off), .receive_rate_output(rx_rate), .transmit_rate_output(tx_rate));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a; reg_wr_data = d; reg_wr_en = 1'b1;
    @(negedge mclk);
    reg_wr_en = 1'b0;
  endtask
  // Expected value is {laser_off, receive rate, transmit rate, read byte}
  task automatic rd(input logic [7:0] a, input logic [10:0] x);
    @(negedge mclk);
    reg_addr = a; reg_rd_en = 1'b1;
    exp_q.push_back(x);
    @(negedge mclk);
    reg_rd_en = 1'b0;
  endtask
  task automatic test_done;
    // A note never answered means a read went missing
    if (exp_q.size() != 0) n_errors++;
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Monitor: one note is consumed per read answer
  always @(posedge mclk) rd_d <= reg_rd_en;
  always @(negedge mclk) begin
    if (rd_d === 1'b1) begin
      exp_note = (exp_q.size() > 0) ? exp_q.pop_front() : 11'h7ff;
      check_count++;
      if ({laser_off, rx_rate, tx_rate, reg_rd_data} !== exp_note) begin
        n_errors++;
        $display("unexpected at %0t: got %h exp %h", $time,
                 {laser_off, rx_rate, tx_rate, reg_rd_data}, exp_note);
      end
    end
  end
  // Watchdog sized well above the ~700 cycles the sequence needs
  initial begin
    #300000;
    n_errors++;
    test_done();
  end
  // ==========================================================
  // Main sequence
  initial begin
    mclk = 1'b0; rst_n = 1'b0; reg_wr_en = 1'b0; reg_rd_en = 1'b0; table_wr_en = 1'b0;
    reg_addr = 8'h00; reg_wr_data = 8'h00; table_wr_idx = 6'h00; table_wr_data = 2'h0;
    pin_req = 5'h00; tx_soft_rate_bit = 1'b0; rd_d = 1'b0; r = 32'h7b5c;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    rd(xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS, 11'h001);
    rd(xcvr_ctl_pkg::OFS_APPLICATION_SELECT_MODE, 11'h000);
    wr(8'h70, 8'hff);
    rd(8'h70, 11'h000);
    rd(xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS, 11'h001);
    rd(xcvr_ctl_pkg::OFS_APPLICATION_SELECT_MODE, 11'h000);
    for (int i = 0; i < 64; i++) begin
      r = lfsr(r);
      tbl[i] = r[1:0];
      @(negedge mclk);
      table_wr_en = 1'b1; table_wr_idx = 6'(i); table_wr_data = r[1:0];
    end
    @(negedge mclk);
    table_wr_en = 1'b0;
    // Every mode code is swept by the loop index; pins and soft bits are random
    for (int i = 0; i < 48; i++) begin
      r = lfsr(r);
      pin_req = r[4:0];
      tx_soft_rate_bit = r[5];
      st = r[15:8];
      m = {2'(i), r[21:16]};
      wr(xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS, st);
      wr(xcvr_ctl_pkg::OFS_APPLICATION_SELECT_MODE, m);
      repeat (4) @(negedge mclk);
      e[10] = r[4] | st[6];
      if (m[7]) e[9:8] = {tbl[m[5:0]][0], tbl[m[5:0]][1]};
      else if (m[6]) e[9:8] = {r[1], r[0]};
      else e[9:8] = {r[1] | st[3], r[5]};
      e[7:0] = {r[4], st[6], r[0], r[1], st[3], r[3], r[2], 1'b0};
      rd(xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS, e);
      rd(xcvr_ctl_pkg::OFS_APPLICATION_SELECT_MODE, {e[10:8], m});
    end
    // Second reset: written fields fall back and the busy bit rearms
    pin_req = 5'h00;
    tx_soft_rate_bit = 1'b0;
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    rd(xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS, 11'h001);
    rd(xcvr_ctl_pkg::OFS_APPLICATION_SELECT_MODE, 11'h000);
    repeat (2) @(negedge mclk);
    test_done();
  end
endmodule // tb_transceiver_control_rate_select

// ==== verilog/rate_table.sv ====
// Rate pair lookup memory for software mode, registered read
`timescale 1ns/1ns
module rate_table #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 2,
  parameter int AW    = 6
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_idx,
  output logic      [WIDTH-1:0] rd_data
);
  // ==========================================================
  // Elaboration check
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("rate_table: DEPTH must equal 2**AW");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rd;
  } tbl_state_t;

  tbl_state_t s_r;
  tbl_state_t s_nxt;

  // ==========================================================
  // Storage
  always_comb begin
    s_nxt    = s_r;
    s_nxt.rd = s_r.mem[rd_idx];
    if (wr_en) begin
      s_nxt.mem[wr_idx] = wr_data;
    end
  end

  // Cleared entries give a defined low rate before software loads the table
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.rd;
endmodule // rate_table

// ==== verilog/transceiver_control_rate_select.sv ====
// Control/status byte and application-select rate steering
`timescale 1ns/1ns
module transceiver_control_rate_select #(
  parameter int TABLE_DEPTH = 64
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rd_data,
  input  wire logic       table_wr_en,
  input  wire logic [5:0] table_wr_idx,
  input  wire logic [1:0] table_wr_data,
  input  wire logic       transmit_off_pin,
  input  wire logic       transmit_fault_pin,
  input  wire logic       receive_signal_lost_pin,
  input  wire logic       rate_sel_a_pin,
  input  wire logic       rate_sel_b_pin,
  input  wire logic       tx_soft_rate_bit,
  input  wire logic       adc_all_converted,
  output logic            laser_off,
  output logic            receive_rate_output,
  output logic            transmit_rate_output
);
  // ==========================================================
  // Elaboration check
  if (TABLE_DEPTH != (1 << xcvr_ctl_pkg::TABLE_SEL_W)) begin : g_bad_depth
    $error("TABLE_DEPTH must match the table-select field");
  end

  typedef struct packed {
    logic       tx_disable_pin_state;
    logic       soft_transmit_off;
    logic       rate_sel_b_input_state;
    logic       rate_sel_a_input_state;
    logic       soft_rate_sel_a;
    logic       transmit_fault_state;
    logic       signal_lost_state;
    logic       power_on_busy;
    logic [7:0] application_select_mode;
    logic       laser_off;
    logic       rx_rate;
    logic       tx_rate;
    logic [7:0] rd_data;
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;
  logic [1:0] tbl_rd_data;
  logic [7:0] control_and_status;
  logic [1:0] mode;

  assign mode = st_r.application_select_mode[xcvr_ctl_pkg::MODE_MSB:xcvr_ctl_pkg::MODE_LSB];

  // ==========================================================
  // Software-mode lookup
  rate_table #(
    .DEPTH (TABLE_DEPTH),
    .WIDTH (xcvr_ctl_pkg::RATE_PAIR_W),
    .AW    (xcvr_ctl_pkg::TABLE_SEL_W)
  ) u_rate_table (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (table_wr_en),
    .wr_idx  (table_wr_idx),
    .wr_data (table_wr_data),
    .rd_idx  (st_r.application_select_mode[xcvr_ctl_pkg::TABLE_SEL_W-1:0]),
    .rd_data (tbl_rd_data)
  );

  // ==========================================================
  // Register image
  always_comb begin
    control_and_status = {st_r.tx_disable_pin_state, st_r.soft_transmit_off,
                          st_r.rate_sel_b_input_state, st_r.rate_sel_a_input_state,
                          st_r.soft_rate_sel_a, st_r.transmit_fault_state,
                          st_r.signal_lost_state, st_r.power_on_busy};
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.tx_disable_pin_state   = transmit_off_pin;
    st_nxt.rate_sel_b_input_state = rate_sel_b_pin;
    st_nxt.rate_sel_a_input_state = rate_sel_a_pin;
    st_nxt.transmit_fault_state   = transmit_fault_pin;
    st_nxt.signal_lost_state      = receive_signal_lost_pin;
    // Once cleared it stays clear until the next reset
    if (adc_all_converted) begin
      st_nxt.power_on_busy = 1'b0;
    end
    if (reg_wr_en && reg_addr == xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS) begin
      st_nxt.soft_transmit_off = reg_wr_data[xcvr_ctl_pkg::BIT_SOFT_TRANSMIT_OFF];
      st_nxt.soft_rate_sel_a   = reg_wr_data[xcvr_ctl_pkg::BIT_SOFT_RATE_SEL_A];
    end
    if (reg_wr_en && reg_addr == xcvr_ctl_pkg::OFS_APPLICATION_SELECT_MODE) begin
      st_nxt.application_select_mode = reg_wr_data;
    end
    // Laser shutdown follows the pin directly, not the one-cycle-old mirror
    st_nxt.laser_off = transmit_off_pin | st_r.soft_transmit_off;
    if (mode[1]) begin
      // Table read is registered, so a new selection lands one cycle later
      st_nxt.rx_rate = tbl_rd_data[0];
      st_nxt.tx_rate = tbl_rd_data[1];
    end else if (mode == xcvr_ctl_pkg::MODE_HARDWARE) begin
      st_nxt.rx_rate = rate_sel_a_pin;
      st_nxt.tx_rate = rate_sel_b_pin;
    end else begin
      st_nxt.rx_rate = rate_sel_a_pin | st_r.soft_rate_sel_a;
      st_nxt.tx_rate = tx_soft_rate_bit;
    end
    if (reg_rd_en) begin
      unique case (reg_addr)
        xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS:      st_nxt.rd_data = control_and_status;
        xcvr_ctl_pkg::OFS_APPLICATION_SELECT_MODE: st_nxt.rd_data = st_r.application_select_mode;
        default:                                   st_nxt.rd_data = xcvr_ctl_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.power_on_busy <= xcvr_ctl_pkg::POR_BUSY_RESET;
      st_r.application_select_mode <= xcvr_ctl_pkg::RST_APPLICATION_SELECT_MODE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rd_data          = st_r.rd_data;
  assign laser_off            = st_r.laser_off;
  assign receive_rate_output  = st_r.rx_rate;
  assign transmit_rate_output = st_r.tx_rate;

  // ==========================================================
  // Checks
  // Pin bits 7, 5 and 4 are checked against the pin two edges back: mirror flop, then read flop
  AST_TX_DISABLE_PIN_STATE_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd_en && reg_addr == xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS && $past(rst_n)
      |=> reg_rd_data[xcvr_ctl_pkg::BIT_TX_DISABLE_PIN_STATE] == $past(transmit_off_pin, 2))
    else $error("status bit 7 does not show transmit-off pin");
  AST_LASER_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    (transmit_off_pin || st_r.soft_transmit_off) |=> laser_off)
    else $error("laser not shut off");
  AST_LASER_ON: assert property (@(posedge mclk) disable iff (!rst_n)
    !transmit_off_pin && !st_r.soft_transmit_off |=> !laser_off)
    else $error("laser held off without cause");
  AST_SOFT_OFF_WR: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr_en && reg_addr == xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS
      |=> st_r.soft_transmit_off == $past(reg_wr_data[xcvr_ctl_pkg::BIT_SOFT_TRANSMIT_OFF]))
    else $error("soft transmit-off bit not written");
  AST_SOFT_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !(reg_wr_en && reg_addr == xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS)
      |=> $stable(st_r.soft_transmit_off) && $stable(st_r.soft_rate_sel_a))
    else $error("soft bit changed without a write");
  AST_RATE_B_STATE: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd_en && reg_addr == xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS && $past(rst_n)
      |=> reg_rd_data[xcvr_ctl_pkg::BIT_RATE_SEL_B_STATE] == $past(rate_sel_b_pin, 2))
    else $error("second rate input not reported");
  AST_RATE_A_STATE: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd_en && reg_addr == xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS && $past(rst_n)
      |=> reg_rd_data[xcvr_ctl_pkg::BIT_RATE_SEL_A_STATE] == $past(rate_sel_a_pin, 2))
    else $error("first rate input not reported");
  AST_SOFT_RATE_WR: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr_en && reg_addr == xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS
      |=> st_r.soft_rate_sel_a == $past(reg_wr_data[xcvr_ctl_pkg::BIT_SOFT_RATE_SEL_A]))
    else $error("soft rate bit not written");
  AST_CTL_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd_en && reg_addr == xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS
      |=> reg_rd_data[xcvr_ctl_pkg::BIT_SOFT_TRANSMIT_OFF] == $past(st_r.soft_transmit_off)
          && reg_rd_data[xcvr_ctl_pkg::BIT_SOFT_RATE_SEL_A] == $past(st_r.soft_rate_sel_a)
          && reg_rd_data[xcvr_ctl_pkg::BIT_POWER_ON_BUSY] == $past(st_r.power_on_busy))
    else $error("writable or busy bit read back wrong");
  AST_FAULT_LOS: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> st_r.transmit_fault_state == $past(transmit_fault_pin)
             && st_r.signal_lost_state == $past(receive_signal_lost_pin))
    else $error("fault or signal-lost mirror wrong");
  AST_POR_DONE: assert property (@(posedge mclk) disable iff (!rst_n)
    adc_all_converted |=> !st_r.power_on_busy [*3])
    else $error("power-on busy not cleared");
  AST_BUSY_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r.power_on_busy && !adc_all_converted |=> st_r.power_on_busy)
    else $error("power-on busy cleared before conversion");
  AST_BUSY_STAYS: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_r.power_on_busy |=> !st_r.power_on_busy)
    else $error("power-on busy set again without reset");
  AST_MODE_WR: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr_en && reg_addr == xcvr_ctl_pkg::OFS_APPLICATION_SELECT_MODE
      |=> st_r.application_select_mode == $past(reg_wr_data))
    else $error("application select byte not written");
  AST_MODE_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !(reg_wr_en && reg_addr == xcvr_ctl_pkg::OFS_APPLICATION_SELECT_MODE)
      |=> $stable(st_r.application_select_mode))
    else $error("application select byte changed without a write");
  AST_MODE_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd_en && reg_addr == xcvr_ctl_pkg::OFS_APPLICATION_SELECT_MODE
      |=> reg_rd_data == $past(st_r.application_select_mode))
    else $error("application select byte read back wrong");
  AST_UNMAPPED_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd_en && reg_addr != xcvr_ctl_pkg::OFS_CONTROL_AND_STATUS
      && reg_addr != xcvr_ctl_pkg::OFS_APPLICATION_SELECT_MODE
      |=> reg_rd_data == xcvr_ctl_pkg::READ_UNMAPPED)
    else $error("unmapped offset did not read as zero");
  AST_RD_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_rd_en |=> $stable(reg_rd_data))
    else $error("read data changed without a read");
  // Busy bit comes back as 1 so the host sees a fresh power-on pass
  AST_RESET_STATE: assert property (@(posedge mclk)
    !rst_n |=> control_and_status[7:1] == xcvr_ctl_pkg::RST_CONTROL_AND_STATUS[7:1]
               && st_r.power_on_busy == xcvr_ctl_pkg::POR_BUSY_RESET
               && st_r.application_select_mode == xcvr_ctl_pkg::RST_APPLICATION_SELECT_MODE
               && !laser_off && !receive_rate_output && !transmit_rate_output)
    else $error("state after reset wrong");
  AST_EMU_RX: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == xcvr_ctl_pkg::MODE_EMULATION
      |=> receive_rate_output == ($past(rate_sel_a_pin) | $past(st_r.soft_rate_sel_a))
          && transmit_rate_output == $past(tx_soft_rate_bit))
    else $error("emulation mode steering wrong");
  AST_HW_MODE: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == xcvr_ctl_pkg::MODE_HARDWARE |=> receive_rate_output == $past(rate_sel_a_pin)
                                            && transmit_rate_output == $past(rate_sel_b_pin))
    else $error("hardware mode steering wrong");
  AST_SW_MODE: assert property (@(posedge mclk) disable iff (!rst_n)
    mode[1] |=> {transmit_rate_output, receive_rate_output} == $past(tbl_rd_data))
    else $error("software mode output not from table");
endmodule // transceiver_control_rate_select

// ==== verilog/xcvr_ctl_pkg.sv ====
// Constants for the transceiver control/status and rate-select block
package xcvr_ctl_pkg;
  // ==========================================================
  // Register offsets and reset values
  localparam logic [7:0] OFS_CONTROL_AND_STATUS      = 8'h6e;
  localparam logic [7:0] OFS_APPLICATION_SELECT_MODE = 8'h6f;
  localparam logic [7:0] RST_CONTROL_AND_STATUS      = 8'h00;
  localparam logic [7:0] RST_APPLICATION_SELECT_MODE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED               = 8'h00;
  // ==========================================================
  // Control and status bit positions
  localparam int BIT_TX_DISABLE_PIN_STATE = 7;
  localparam int BIT_SOFT_TRANSMIT_OFF    = 6;
  localparam int BIT_RATE_SEL_B_STATE     = 5;
  localparam int BIT_RATE_SEL_A_STATE     = 4;
  localparam int BIT_SOFT_RATE_SEL_A      = 3;
  localparam int BIT_TRANSMIT_FAULT_STATE = 2;
  localparam int BIT_SIGNAL_LOST_STATE    = 1;
  localparam int BIT_POWER_ON_BUSY        = 0;
  // ==========================================================
  // Application select fields
  localparam int MODE_MSB      = 7;
  localparam int MODE_LSB      = 6;
  localparam int TABLE_SEL_W   = 6;
  localparam int RATE_PAIR_W   = 2;
  localparam logic [1:0] MODE_EMULATION = 2'h0;
  localparam logic [1:0] MODE_HARDWARE  = 2'h1;
  localparam logic       POR_BUSY_RESET = 1'b1;
endpackage
